//--- dpw_regs.svh
// Constants of the wiper control link and its controller registers
`ifndef DPW_REGS_SVH
`define DPW_REGS_SVH
`define DPW_MIDSCALE 8'h80
`define DPW_B_TAP 8'h00
`define DPW_TAP_RST (256'h1 << 8'h80)
`define DPW_ACK_CNT 4'h8
`define DPW_INS_MID 6
`define DPW_INS_PD 5
`define DPW_REG_CTRL 2'h0
`define DPW_REG_DATA 2'h1
`define DPW_REG_STAT 2'h2
`define DPW_CTRL_GO 0
`define DPW_CTRL_READ 1
`define DPW_CTRL_MID 2
`define DPW_CTRL_PD 3
`define DPW_CTRL_SEL 4
`define DPW_CLK_NS 10
`define DPW_SCL_QTR_NS 2500
`endif

//--- dpw_pkg.sv
// Types shared by both ends of the wiper control link
package dpw_pkg;
  typedef enum logic [9:0] {
    D_IDLE = 10'h001,
    D_ADDR = 10'h002,
    D_AACK = 10'h004,
    D_INS = 10'h008,
    D_IACK = 10'h010,
    D_DAT = 10'h020,
    D_DACK = 10'h040,
    D_RD = 10'h080,
    D_RACK = 10'h100,
    D_WAIT = 10'h200
  } dpw_dst_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } dpw_hst_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] sel_s;
    logic scl_f;
    logic sda_f;
    logic sel_f;
    dpw_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ins;
    logic rw;
    logic sda_oe;
    logic [7:0] wiper;
    logic pd;
    logic [255:0] tap;
  } dpw_dev_t;

  typedef struct packed {
    logic [2:0] sda_s;
    logic sda_f;
    dpw_hst_t st;
    logic [1:0] ph;
    logic [15:0] qc;
    logic [1:0] bidx;
    logic [3:0] bitn;
    logic rd;
    logic mid;
    logic pdn;
    logic sel;
    logic [7:0] wdat;
    logic [7:0] rxd;
    logic busy;
    logic nack;
    logic done;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] rdata;
  } dpw_host_t;
endpackage

//--- dpw_if.sv
// Two-wire link between the controller and the wiper device
interface dpw_if;
  logic scl_oe_h;
  logic sda_oe_h;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // Open-drain wires: any enabled driver pulls low
  assign scl = ~scl_oe_h;
  assign sda = ~(sda_oe_h | sda_oe_d);
  modport dev (input scl, input sda, output sda_oe_d);
  modport host (input scl, input sda, output scl_oe_h, output sda_oe_h);
endinterface

//--- dpw_dev.sv
// Wiper device end: bus slave, wiper register and tap decoder
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "dpw_regs.svh"
module dpw_dev #(
  parameter logic [5:0] DEV_PREFIX = 6'h2A // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  dpw_if.dev bus,
  input wire logic address_select_pin,
  output logic [7:0] wiper_position,
  output logic power_down,
  output logic [255:0] tap_sel
);

  dpw_pkg::dpw_dev_t r_r;
  dpw_pkg::dpw_dev_t r_nxt;

  // Next-state logic for the whole device
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic match;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    match = 1'b0;
    r_nxt = r_r;

    // Three-stage synchronisers; first stage feeds only the second
    r_nxt.scl_s = {r_r.scl_s[1:0], bus.scl};
    r_nxt.sda_s = {r_r.sda_s[1:0], bus.sda};
    r_nxt.sel_s = {r_r.sel_s[1:0], address_select_pin};

    // A change counts once stages two and three agree
    if (r_r.scl_s[1] == r_r.scl_s[2]) begin
      r_nxt.scl_f = r_r.scl_s[2];
    end
    if (r_r.sda_s[1] == r_r.sda_s[2]) begin
      r_nxt.sda_f = r_r.sda_s[2];
    end
    if (r_r.sel_s[1] == r_r.sel_s[2]) begin
      r_nxt.sel_f = r_r.sel_s[2];
    end

    // Edges and bus conditions from filtered levels
    rise = r_nxt.scl_f & ~r_r.scl_f;
    fall = ~r_nxt.scl_f & r_r.scl_f;
    start = r_r.scl_f & r_nxt.scl_f & r_r.sda_f & ~r_nxt.sda_f;
    stop = r_r.scl_f & r_nxt.scl_f & ~r_r.sda_f & r_nxt.sda_f;

    // Address check: fixed prefix, select pin bit
    match = (r_r.sh[7:2] == DEV_PREFIX) && (r_r.sh[1] == r_r.sel_f);

    if (start) begin
      // Repeated start drops any half-done transfer
      r_nxt.st = dpw_pkg::D_ADDR;
      r_nxt.cnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      // Early stop: wiper and power-down untouched
      r_nxt.st = dpw_pkg::D_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.st)
        dpw_pkg::D_IDLE: begin
          // Nothing but a start wakes us up
          r_nxt.sda_oe = 1'b0;
        end
        dpw_pkg::D_ADDR: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], r_nxt.sda_f};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (fall && r_r.cnt == `DPW_ACK_CNT) begin
            if (match) begin
              r_nxt.sda_oe = 1'b1;
              r_nxt.rw = r_r.sh[0];
              r_nxt.st = dpw_pkg::D_AACK;
            end else begin
              // Not ours: stay off the bus until next start
              r_nxt.st = dpw_pkg::D_WAIT;
            end
          end
        end
        dpw_pkg::D_AACK: begin
          if (fall) begin
            r_nxt.cnt = 4'h0;
            if (r_r.rw) begin
              // Present the MSB as soon as the ack slot ends
              r_nxt.sh = r_r.wiper;
              r_nxt.sda_oe = ~r_r.wiper[7];
              r_nxt.st = dpw_pkg::D_RD;
            end else begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = dpw_pkg::D_INS;
            end
          end
        end
        dpw_pkg::D_INS: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], r_nxt.sda_f};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (fall && r_r.cnt == `DPW_ACK_CNT) begin
            // Instruction held until the data byte completes
            r_nxt.ins = r_r.sh;
            r_nxt.sda_oe = 1'b1;
            r_nxt.st = dpw_pkg::D_IACK;
          end
        end
        dpw_pkg::D_IACK: begin
          if (fall) begin
            r_nxt.cnt = 4'h0;
            r_nxt.sda_oe = 1'b0;
            r_nxt.st = dpw_pkg::D_DAT;
          end
        end
        dpw_pkg::D_DAT: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], r_nxt.sda_f};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (fall && r_r.cnt == `DPW_ACK_CNT) begin
            r_nxt.sda_oe = 1'b1;
            r_nxt.st = dpw_pkg::D_DACK;
          end
        end
        dpw_pkg::D_DACK: begin
          if (fall) begin
            r_nxt.sda_oe = 1'b0;
            // Applied only here, so an abort never half-applies
            if (r_r.ins[`DPW_INS_MID]) begin
              r_nxt.wiper = `DPW_MIDSCALE;
            end else begin
              r_nxt.wiper = r_r.sh;
            end
            // Top instruction bit is never looked at
            r_nxt.pd = r_r.ins[`DPW_INS_PD];
            // Third byte ends the write; more are not acked
            r_nxt.st = dpw_pkg::D_WAIT;
          end
        end
        dpw_pkg::D_RD: begin
          if (rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (fall) begin
            if (r_r.cnt == `DPW_ACK_CNT) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = dpw_pkg::D_RACK;
            end else begin
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.sda_oe = ~r_r.sh[6];
            end
          end
        end
        dpw_pkg::D_RACK: begin
          if (rise) begin
            if (!r_nxt.sda_f) begin
              // Master wants more: resend on next falling edge
              r_nxt.st = dpw_pkg::D_AACK;
            end else begin
              r_nxt.st = dpw_pkg::D_WAIT;
            end
          end
        end
        dpw_pkg::D_WAIT: begin
          r_nxt.sda_oe = 1'b0;
        end
        default: begin
          r_nxt.st = dpw_pkg::D_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // One-hot tap; power-down parks on bottom, register kept
    r_nxt.tap = '0;
    if (r_nxt.pd) begin
      r_nxt.tap[`DPW_B_TAP] = 1'b1;
    end else begin
      r_nxt.tap[r_nxt.wiper] = 1'b1;
    end
  end

  // State register; volatile wiper starts at midscale
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.scl_s <= 3'h7;
      r_r.sda_s <= 3'h7;
      r_r.scl_f <= 1'b1;
      r_r.sda_f <= 1'b1;
      r_r.st <= dpw_pkg::D_IDLE;
      r_r.wiper <= `DPW_MIDSCALE;
      r_r.tap <= `DPW_TAP_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register
  assign bus.sda_oe_d = r_r.sda_oe;
  assign wiper_position = r_r.wiper;
  assign power_down = r_r.pd;
  assign tap_sel = r_r.tap;

endmodule // dpw_dev

//--- dpw_host.sv
// Bus master end: register port in, two-wire transfers out
`include "dpw_regs.svh"
module dpw_host #(
  parameter logic [5:0] DEV_PREFIX = 6'h2A, // Arbitrary value
  parameter int QTR_CYC = (`DPW_SCL_QTR_NS + `DPW_CLK_NS - 1) / `DPW_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  dpw_if.host bus,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);

  // Quarter bit must leave room for the far end's input filter
  if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_qtr_chk
    $error("QTR_CYC out of range");
  end

  localparam logic [15:0] QLAST = 16'(QTR_CYC - 1);

  dpw_pkg::dpw_host_t r_r;
  dpw_pkg::dpw_host_t r_nxt;

  // Next-state logic: register port and bit sequencer
  always_comb begin
    logic tick;
    logic tx;
    logic last;
    logic [7:0] cur;
    r_nxt = r_r;
    cur = 8'h00;
    tick = r_r.busy && (r_r.qc == QLAST);
    tx = !(r_r.rd && r_r.bidx == 2'h1);
    last = r_r.rd ? (r_r.bidx == 2'h1) : (r_r.bidx == 2'h2);
    case (r_r.bidx)
      2'h0: cur = {DEV_PREFIX, r_r.sel, r_r.rd};
      2'h1: cur = {1'b0, r_r.mid, r_r.pdn, 5'h00};
      default: cur = r_r.wdat;
    endcase

    // Sync data line; only stages two and three are compared
    r_nxt.sda_s = {r_r.sda_s[1:0], bus.sda};
    if (r_r.sda_s[1] == r_r.sda_s[2]) begin
      r_nxt.sda_f = r_r.sda_s[2];
    end

    // Read data valid in the cycle after the strobe only
    r_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `DPW_REG_CTRL: r_nxt.rdata = {3'h0, r_r.sel, r_r.pdn, r_r.mid, r_r.rd, r_r.busy};
        `DPW_REG_DATA: r_nxt.rdata = r_r.rxd;
        `DPW_REG_STAT: r_nxt.rdata = {5'h00, r_r.done, r_r.nack, r_r.busy};
        default: r_nxt.rdata = 8'h00;
      endcase
    end
    if (wr && addr == `DPW_REG_DATA) begin
      r_nxt.wdat = wdata;
    end
    // Go is ignored while a transfer runs
    if (wr && addr == `DPW_REG_CTRL && wdata[`DPW_CTRL_GO] && !r_r.busy) begin
      r_nxt.rd = wdata[`DPW_CTRL_READ];
      r_nxt.mid = wdata[`DPW_CTRL_MID];
      r_nxt.pdn = wdata[`DPW_CTRL_PD];
      r_nxt.sel = wdata[`DPW_CTRL_SEL];
      r_nxt.busy = 1'b1;
      r_nxt.nack = 1'b0;
      r_nxt.done = 1'b0;
      r_nxt.st = dpw_pkg::H_START;
      r_nxt.ph = 2'h0;
      r_nxt.qc = 16'h0000;
    end

    if (r_r.busy) begin
      r_nxt.qc = tick ? 16'h0000 : r_r.qc + 16'h0001;
    end

    if (tick) begin
      r_nxt.ph = r_r.ph + 2'h1;
      case (r_r.st)
        dpw_pkg::H_START: begin
          if (r_r.ph == 2'h0) begin
            r_nxt.sda_oe = 1'b1;
          end else begin
            r_nxt.scl_oe = 1'b1;
            r_nxt.st = dpw_pkg::H_BIT;
            r_nxt.ph = 2'h0;
            r_nxt.bidx = 2'h0;
            r_nxt.bitn = 4'h0;
          end
        end
        dpw_pkg::H_BIT: begin
          case (r_r.ph)
            // Data changes only while the clock is low
            2'h0: r_nxt.sda_oe = tx && r_r.bitn != `DPW_ACK_CNT
                                 && !cur[3'h7 - r_r.bitn[2:0]];
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (r_r.bitn == `DPW_ACK_CNT && tx && r_nxt.sda_f) begin
                r_nxt.nack = 1'b1;
              end
              if (r_r.bitn != `DPW_ACK_CNT && !tx) begin
                r_nxt.rxd = {r_r.rxd[6:0], r_nxt.sda_f};
              end
            end
            default: begin
              r_nxt.scl_oe = 1'b1;
              if (r_r.bitn == `DPW_ACK_CNT) begin
                r_nxt.bitn = 4'h0;
                r_nxt.bidx = r_r.bidx + 2'h1;
                if (last || r_r.nack) begin
                  r_nxt.st = dpw_pkg::H_STOP;
                end
              end else begin
                r_nxt.bitn = r_r.bitn + 4'h1;
              end
            end
          endcase
        end
        dpw_pkg::H_STOP: begin
          case (r_r.ph)
            2'h0: r_nxt.sda_oe = 1'b1;
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2: r_nxt.sda_oe = 1'b0;
            default: begin
              r_nxt.st = dpw_pkg::H_IDLE;
              r_nxt.busy = 1'b0;
              r_nxt.done = 1'b1;
            end
          endcase
        end
        default: begin
          r_nxt.st = dpw_pkg::H_IDLE;
        end
      endcase
    end
  end

  // State register; both lines released at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.sda_s <= 3'h7;
      r_r.sda_f <= 1'b1;
      r_r.st <= dpw_pkg::H_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus.scl_oe_h = r_r.scl_oe;
  assign bus.sda_oe_h = r_r.sda_oe;
  assign rdata = r_r.rdata;

endmodule // dpw_host

//--- dpw_link_asserts.sv
// Link checker: bus timing and wiper outputs of the device end
module dpw_link_asserts #(
  parameter logic [5:0] DEV_PREFIX = 6'h2A // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_d,
  input wire logic address_select_pin,
  input wire logic [7:0] wiper_position,
  input wire logic power_down,
  input wire logic [255:0] tap_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q;
  logic sda_q;
  logic [5:0] bitc;
  logic [7:0] adr;
  logic rise;
  logic hit;
  // Raw wire edges; the device filters, so these lead its view
  assign rise = scl && !scl_q;
  assign hit = (adr[7:2] == DEV_PREFIX) && (adr[1] == address_select_pin);
  // Clock rises since start, address byte gathered MSB first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitc <= 6'h3F;
      adr <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bitc <= 6'h00;
      end else if (rise) begin
        bitc <= (bitc == 6'h3F) ? bitc : bitc + 6'h01;
        adr <= (bitc < 6'h08) ? {adr[6:0], sda} : adr;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stop;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence s_ninth;
    rise && bitc == 6'h08;
  endsequence
  chk_reset_mid: assert property ($rose(rst_n) |-> wiper_position == 8'h80 && !power_down)
    else $error("wiper not at midscale after reset");
  chk_tap_onehot: assert property (!power_down && $stable(wiper_position) && $stable(power_down)
    |-> tap_sel == (256'h1 << wiper_position))
    else $error("tap selection differs from wiper");
  chk_tap_parked: assert property (power_down && $past(power_down) |-> tap_sel == 256'h1)
    else $error("tap not parked in power down");
  chk_wiper_scl_low: assert property ($changed(wiper_position) || $changed(power_down) |-> !scl)
    else $error("wiper moved while clock high");
  chk_sda_clk_low: assert property ($changed(sda_oe_d) |-> !scl && !$past(scl))
    else $error("device data changed near clock high");
  chk_addr_quiet: assert property (rise && bitc < 6'h08 |-> !sda_oe_d)
    else $error("device drove during address bits");
  chk_addr_ack: assert property (s_ninth |-> sda_oe_d == hit)
    else $error("address acknowledge wrong");
  chk_write_ack: assert property (rise && !adr[0] && hit && (bitc == 6'h11 || bitc == 6'h1A)
    |-> sda_oe_d)
    else $error("write byte not acknowledged");
  chk_read_bits: assert property (rise && adr[0] && hit && bitc > 6'h08 && bitc < 6'h11
    |-> sda == wiper_position[3'(16 - bitc)])
    else $error("read bit differs from wiper");
  chk_read_release: assert property (rise && adr[0] && bitc > 6'h10 && bitc < 6'h3F
    |-> !sda_oe_d)
    else $error("device drove after read byte");
  chk_stop_release: assert property (s_stop |=> !sda_oe_d [*4])
    else $error("device drove after stop");
  // Wiper state may move only after the data byte of a finished write
  chk_wiper_at_ack: assert property ($changed(wiper_position) || $changed(power_down)
    |-> bitc == 6'h1B && !adr[0] && hit)
    else $error("wiper moved outside a finished write");
endmodule // dpw_link_asserts

//--- testbench.sv
// Testbench: controller and wiper device joined over the link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] PFX = 6'h2A; // Arbitrary value
  logic sys_clk, rst_n, wr, rd, address_select_pin, power_down;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, wiper_position, s, d;
  logic [255:0] tap_sel;
  int mismatches, num_checks;
  dpw_if bus_if();
  dpw_dev #(.DEV_PREFIX(PFX)) i_dpw_dev(.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if),
    .address_select_pin(address_select_pin), .wiper_position(wiper_position),
    .power_down(power_down), .tap_sel(tap_sel));
  // Short quarter bit keeps each transfer under a thousand cycles
  dpw_host #(.DEV_PREFIX(PFX), .QTR_CYC(8)) i_dpw_host(.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  dpw_link_asserts #(.DEV_PREFIX(PFX)) i_dpw_link_asserts(.sys_clk(sys_clk), .rst_n(rst_n),
    .scl(bus_if.scl), .sda(bus_if.sda), .sda_oe_d(bus_if.sda_oe_d),
    .address_select_pin(address_select_pin), .wiper_position(wiper_position),
    .power_down(power_down), .tap_sel(tap_sel));
  // System clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s: got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Register port: one-cycle strobes, read data in the next cycle
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // Start a transfer, poll busy under a bound
  task automatic xfer(input logic [7:0] c, input logic [7:0] v);
    int n;
    wr_reg(2'h1, v);
    wr_reg(2'h0, c);
    s = 8'h01;
    for (n = 0; n < 3000 && s[0] !== 1'b0; n++) rd_reg(2'h2, s);
    if (s[0] !== 1'b0) begin
      mismatches++;
      $display("BAD %0t transfer never finished", $time);
      end_of_test();
    end
  endtask
  task automatic wr_pot(input logic [7:0] c, v, w, input logic pd, input logic [255:0] t,
    input logic [7:0] st);
    xfer(c, v);
    chk(s, st, "status");
    chk({power_down, wiper_position}, {pd, w}, "wiper state");
    chk(tap_sel, t, "taps");
    $display("write ctrl %h data %h ends", c, v);
  endtask
  task automatic rd_pot(input logic [7:0] c, input logic [7:0] exp);
    xfer(c, 8'h00);
    chk(s, 8'h04, "read status");
    rd_reg(2'h1, d);
    chk(d, exp, "read byte");
    $display("read ctrl %h ends", c);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    address_select_pin = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({power_down, wiper_position}, 9'h080, "reset wiper");
    chk(tap_sel, 256'h1 << 8'h80, "reset taps");
    $display("reset test ends");
    repeat (4) @(posedge sys_clk);
    wr_pot(8'h01, 8'h37, 8'h37, 1'b0, 256'h1 << 8'h37, 8'h04);
    rd_pot(8'h03, 8'h37);
    wr_pot(8'h11, 8'h99, 8'h37, 1'b0, 256'h1 << 8'h37, 8'h06);
    @(posedge sys_clk);
    address_select_pin <= 1'b1;
    wr_pot(8'h19, 8'hC4, 8'hC4, 1'b1, 256'h1, 8'h04);
    rd_pot(8'h13, 8'hC4);
    wr_pot(8'h11, 8'hC4, 8'hC4, 1'b0, 256'h1 << 8'hC4, 8'h04);
    wr_pot(8'h15, 8'h11, 8'h80, 1'b0, 256'h1 << 8'h80, 8'h04);
    rd_reg(2'h0, d);
    chk(d, 8'h14, "control readback");
    wr_pot(8'h11, 8'h00, 8'h00, 1'b0, 256'h1, 8'h04);
    wr_pot(8'h11, 8'hFF, 8'hFF, 1'b0, 256'h1 << 8'hFF, 8'h04);
    rd_pot(8'h13, 8'hFF);
    rd_reg(2'h3, d);
    chk(d, 8'h00, "unmapped read");
    end_of_test();
  end
endmodule // testbench
